// *** core/sscm_pkg.sv ***
// constants, field layout and types for the scan sequencer channel map
`default_nettype none
package sscm_pkg;
   // clock and step times
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned SW_STEP_US = 20; // output-switch step
   localparam int unsigned MUX_STEP_US = 4; // mux settle step
   localparam int unsigned SW_STEP_CYC = SW_STEP_US * (CLK_HZ / 1_000_000);
   localparam int unsigned MUX_STEP_CYC = MUX_STEP_US * (CLK_HZ / 1_000_000);
   // register addresses
   localparam logic [3:0] ADDR_SEQ = 4'h4;
   localparam logic [3:0] ADDR_MAP = 4'h5;
   // sequencer control field positions and reset values
   localparam int unsigned SEQ_SW_BIT = 10;
   localparam int unsigned SEQ_MUX_BIT = 9;
   localparam int unsigned SEQ_RDY_BIT = 8;
   localparam int unsigned SEQ_FREQ_LSB = 0;
   localparam logic [1:0] FREQ_RST = 2'h1;
   // scan positions that are never valid
   localparam logic [2:0] POS_NONE = 3'h0;
   localparam logic [2:0] POS_RSVD = 3'h7;
   localparam int unsigned DATA_W = 24;
   localparam int unsigned CH_W = 8;
   // one channel's map byte, msb first
   typedef struct packed {
      logic [2:0] bump_sel;
      logic [2:0] position;
      logic scan_en;
      logic bump_en;
   } sscm_chan_s;
   // register access request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [DATA_W-1:0] wdata;
   } sscm_req_s;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SWITCH,
      ST_SETTLE,
      ST_CONVERT
   } sscm_state_e;
endpackage
`default_nettype wire

// *** core/sscm_core.sv ***
// scan sequencer control bits and channel map for channels 3 to 5
`default_nettype none
module sscm_core #(
   parameter int unsigned NCH = 3,
   parameter int unsigned CHAN_BASE = 3,
   parameter int unsigned NUM_SCAN = 6,
   parameter int unsigned GPO_NUM = 6,
   parameter int unsigned SW_LEN = sscm_pkg::SW_STEP_CYC,
   parameter int unsigned MUX_LEN = sscm_pkg::MUX_STEP_CYC
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // register access
   input wire sscm_pkg::sscm_req_s reg_req,
   output logic [sscm_pkg::DATA_W-1:0] reg_rdata,
   // delay values from the delay register
   input wire logic [7:0] switch_delay_steps,
   input wire logic [7:0] mux_delay_steps,
   // converter handshake
   input wire logic scan_start,
   input wire logic conv_done,
   output logic conv_start,
   // selection, bumps and data ready
   output logic [2:0] chan_select,
   output logic chan_select_valid,
   output logic [GPO_NUM-1:0] gpo_drive,
   output logic data_ready_n,
   // configuration and status
   output logic [1:0] fifo_clock_range,
   output logic output_mapping_error,
   output logic scan_order_error,
   output logic scan_active
);
   localparam int unsigned IW = (NCH > 1) ? $clog2(NCH) : 1;
   localparam logic [2:0] SCAN_MAX = 3'(NUM_SCAN);
   localparam logic [15:0] SW_L = 16'(SW_LEN);
   localparam logic [15:0] MUX_L = 16'(MUX_LEN);

   // refuse settings the logic cannot serve
   // dwell must hold 255 full steps, so step lengths stay below 4113
   if (NCH < 2 || NCH * sscm_pkg::CH_W > sscm_pkg::DATA_W || GPO_NUM > 8
       || NUM_SCAN > 6 || CHAN_BASE + NCH > 8 || SW_LEN < 1
       || MUX_LEN < 1 || SW_LEN > 4112 || MUX_LEN > 4112) begin : g_chk
      $error("sscm_core: unsupported parameters");
   end

   // register state
   logic sw_en, next_sw_en; // output-switch delay enable
   logic mux_en, next_mux_en; // mux settle delay enable
   logic rdy_sup, next_rdy_sup; // ready suppress
   logic [1:0] next_freq;
   logic [sscm_pkg::DATA_W-1:0] next_rdata;
   sscm_pkg::sscm_chan_s [NCH-1:0] map_q, next_map;
   logic wr_seq, wr_map; // decoded writes

   // scan state
   sscm_pkg::sscm_state_e state, next_state;
   logic [IW-1:0] sel_idx, next_sel_idx;
   logic [2:0] last_pos, next_last_pos; // position just visited
   logic [2:0] next_chan;
   logic next_valid, next_cs, next_rdy_n;
   logic [GPO_NUM-1:0] next_gpo;
   logic [7:0] steps, next_steps; // delay steps left
   logic [7:0] loaded, next_loaded; // steps loaded at entry
   logic [15:0] cyc, next_cyc; // cycles within a step
   logic [19:0] dwell, next_dwell; // cycles spent in state
   logic [15:0] step_len;
   logic found, do_pick;
   logic [IW-1:0] best_idx;
   logic [2:0] best_pos;
   logic next_map_err, next_ord_err;

   assign scan_active = (state != sscm_pkg::ST_IDLE);
   assign wr_seq = reg_req.wr && (reg_req.addr == sscm_pkg::ADDR_SEQ);
   assign wr_map = reg_req.wr && (reg_req.addr == sscm_pkg::ADDR_MAP);

   // register writes and read data
   always_comb begin
      next_sw_en = sw_en;
      next_mux_en = mux_en;
      next_rdy_sup = rdy_sup;
      next_freq = fifo_clock_range;
      next_map = map_q;
      next_rdata = reg_rdata;
      if (wr_seq) begin
         next_sw_en = reg_req.wdata[sscm_pkg::SEQ_SW_BIT];
         next_mux_en = reg_req.wdata[sscm_pkg::SEQ_MUX_BIT];
         next_rdy_sup = reg_req.wdata[sscm_pkg::SEQ_RDY_BIT];
         next_freq = reg_req.wdata[sscm_pkg::SEQ_FREQ_LSB +: 2];
      end
      // a write mid-scan is dropped so the walk stays coherent
      if (wr_map && !scan_active) begin
         next_map = reg_req.wdata[NCH*sscm_pkg::CH_W-1:0];
      end
      if (reg_req.rd) begin
         next_rdata = '0; // unmapped and reserved read zero
         case (reg_req.addr)
            sscm_pkg::ADDR_SEQ: begin
               next_rdata[sscm_pkg::SEQ_SW_BIT] = sw_en;
               next_rdata[sscm_pkg::SEQ_MUX_BIT] = mux_en;
               next_rdata[sscm_pkg::SEQ_RDY_BIT] = rdy_sup;
               next_rdata[sscm_pkg::SEQ_FREQ_LSB +: 2] = fifo_clock_range;
            end
            sscm_pkg::ADDR_MAP: next_rdata[NCH*sscm_pkg::CH_W-1:0] = map_q;
            default: next_rdata = '0;
         endcase
      end
   end

   // register flops
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         sw_en <= 1'b0;
         mux_en <= 1'b0;
         rdy_sup <= 1'b0;
         fifo_clock_range <= sscm_pkg::FREQ_RST;
         map_q <= '0;
         reg_rdata <= '0;
      end else begin
         sw_en <= next_sw_en;
         mux_en <= next_mux_en;
         rdy_sup <= next_rdy_sup;
         fifo_clock_range <= next_freq;
         map_q <= next_map;
         reg_rdata <= next_rdata;
      end
   end

   // next channel: lowest valid position above the last one
   always_comb begin
      found = 1'b0;
      best_idx = '0;
      best_pos = sscm_pkg::POS_RSVD;
      for (int i = 0; i < NCH; i++) begin
         if (map_q[i].scan_en
             && map_q[i].position > last_pos
             && map_q[i].position <= SCAN_MAX
             && map_q[i].position != sscm_pkg::POS_RSVD
             && (!found || map_q[i].position < best_pos)) begin
            found = 1'b1;
            best_idx = IW'(i);
            best_pos = map_q[i].position;
         end
      end
   end

   // scan walk: bump, switch delay, select, settle, convert
   always_comb begin
      next_state = state;
      next_sel_idx = sel_idx;
      next_last_pos = last_pos;
      next_chan = chan_select;
      next_valid = chan_select_valid;
      next_gpo = gpo_drive;
      next_cs = 1'b0;
      next_rdy_n = 1'b1;
      next_steps = steps;
      next_loaded = loaded;
      next_cyc = cyc;
      do_pick = 1'b0;
      step_len = (state == sscm_pkg::ST_SWITCH) ? SW_L : MUX_L;
      case (state)
         sscm_pkg::ST_IDLE: begin
            if (scan_start && found) begin
               do_pick = 1'b1;
            end
         end
         sscm_pkg::ST_SWITCH, sscm_pkg::ST_SETTLE: begin
            if (steps == 8'h00) begin
               if (state == sscm_pkg::ST_SWITCH) begin
                  next_valid = 1'b1;
                  next_state = sscm_pkg::ST_SETTLE;
                  next_steps = mux_en ? mux_delay_steps : 8'h00;
                  next_loaded = next_steps;
                  next_cyc = '0;
               end else begin
                  next_cs = 1'b1;
                  next_state = sscm_pkg::ST_CONVERT;
               end
            end else if (cyc == step_len - 16'h0001) begin
               next_cyc = '0;
               next_steps = steps - 8'h01;
            end else begin
               next_cyc = cyc + 16'h0001;
            end
         end
         sscm_pkg::ST_CONVERT: begin
            if (conv_done && found) begin
               next_rdy_n = rdy_sup;
               do_pick = 1'b1;
            end else if (conv_done) begin
               // scan over: release bump and selection
               next_rdy_n = 1'b0;
               next_valid = 1'b0;
               next_gpo = '0;
               next_last_pos = sscm_pkg::POS_NONE;
               next_state = sscm_pkg::ST_IDLE;
            end
         end
         default: next_state = sscm_pkg::ST_IDLE;
      endcase
      if (do_pick) begin
         next_sel_idx = best_idx;
         next_last_pos = best_pos;
         next_chan = 3'(CHAN_BASE) + 3'(best_idx);
         next_valid = 1'b0;
         next_gpo = '0;
         // out-of-range bump codes drive nothing
         if (map_q[best_idx].bump_en
             && {1'b0, map_q[best_idx].bump_sel} < 4'(GPO_NUM)) begin
            next_gpo[map_q[best_idx].bump_sel] = 1'b1;
         end
         next_state = sscm_pkg::ST_SWITCH;
         next_steps = sw_en ? switch_delay_steps : 8'h00;
         next_loaded = next_steps;
         next_cyc = '0;
      end
      next_dwell = (next_state != state) ? 20'h0_0000 : dwell + 20'h0_0001;
   end

   // scan flops
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= sscm_pkg::ST_IDLE;
         sel_idx <= '0;
         last_pos <= sscm_pkg::POS_NONE;
         chan_select <= 3'h0;
         chan_select_valid <= 1'b0;
         gpo_drive <= '0;
         conv_start <= 1'b0;
         data_ready_n <= 1'b1;
         steps <= 8'h00;
         loaded <= 8'h00;
         cyc <= '0;
         dwell <= '0;
      end else begin
         state <= next_state;
         sel_idx <= next_sel_idx;
         last_pos <= next_last_pos;
         chan_select <= next_chan;
         chan_select_valid <= next_valid;
         gpo_drive <= next_gpo;
         conv_start <= next_cs;
         data_ready_n <= next_rdy_n;
         steps <= next_steps;
         loaded <= next_loaded;
         cyc <= next_cyc;
         dwell <= next_dwell;
      end
   end

   // error flags follow the map, one cycle behind
   always_comb begin
      next_map_err = 1'b0;
      next_ord_err = 1'b0;
      for (int i = 0; i < NCH; i++) begin
         if (map_q[i].scan_en && (map_q[i].position == sscm_pkg::POS_NONE
             || map_q[i].position == sscm_pkg::POS_RSVD
             || map_q[i].position > SCAN_MAX)) begin
            next_ord_err = 1'b1;
         end
         for (int j = i + 1; j < NCH; j++) begin
            if (map_q[i].bump_en && map_q[j].bump_en
                && map_q[i].bump_sel == map_q[j].bump_sel) begin
               next_map_err = 1'b1;
            end
         end
      end
   end

   // status flops
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         output_mapping_error <= 1'b0;
         scan_order_error <= 1'b0;
      end else begin
         output_mapping_error <= next_map_err;
         scan_order_error <= next_ord_err;
      end
   end

   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   sequence s_map_wr_bad3;
      wr_map && !scan_active && reg_req.wdata[1]
      && reg_req.wdata[4:2] == sscm_pkg::POS_NONE;
   endsequence
   property p_order_err;
      s_map_wr_bad3 |=> ##1 scan_order_error;
   endproperty
   a_order_err: assert property (p_order_err)
      else $error("order error flag not raised");

   property p_map_err;
      (map_q[0].bump_en && map_q[1].bump_en
       && map_q[0].bump_sel == map_q[1].bump_sel) |=> output_mapping_error;
   endproperty
   a_map_err: assert property (p_map_err)
      else $error("mapping error flag not raised");

   property p_map_lock;
      (wr_map && scan_active) |=> $stable(map_q);
   endproperty
   a_map_lock: assert property (p_map_lock)
      else $error("map changed during a scan");

   property p_sel_en;
      chan_select_valid |-> map_q[sel_idx].scan_en;
   endproperty
   a_sel_en: assert property (p_sel_en)
      else $error("disabled channel selected");

   property p_bump;
      (|gpo_drive) |-> scan_active && map_q[sel_idx].bump_en
         && gpo_drive[map_q[sel_idx].bump_sel];
   endproperty
   a_bump: assert property (p_bump)
      else $error("bump driven without enable");

   property p_sw_time;
      (state == sscm_pkg::ST_SWITCH && steps == 8'h00)
         |-> dwell == 20'(loaded) * 20'(SW_LEN) ##1 chan_select_valid;
   endproperty
   a_sw_time: assert property (p_sw_time)
      else $error("switch delay length wrong");

   sequence s_settle_end;
      state == sscm_pkg::ST_SETTLE && steps == 8'h00;
   endsequence
   property p_mux_time;
      s_settle_end |-> dwell == 20'(loaded) * 20'(MUX_LEN) ##1 conv_start;
   endproperty
   a_mux_time: assert property (p_mux_time)
      else $error("mux delay length wrong");

   property p_ready_hold;
      (state == sscm_pkg::ST_CONVERT && conv_done && found && rdy_sup)
         |=> data_ready_n && state == sscm_pkg::ST_SWITCH;
   endproperty
   a_ready_hold: assert property (p_ready_hold)
      else $error("data ready not suppressed");

   property p_ascend;
      (state == sscm_pkg::ST_CONVERT && conv_done && found)
         |=> last_pos > $past(last_pos);
   endproperty
   a_ascend: assert property (p_ascend)
      else $error("scan order not ascending");

   property p_freq;
      wr_seq |=> fifo_clock_range
         == $past(reg_req.wdata[sscm_pkg::SEQ_FREQ_LSB +: 2]);
   endproperty
   a_freq: assert property (p_freq)
      else $error("fifo clock range not stored");
endmodule
`default_nettype wire

// *** bench/sscm_host.sv ***
// host model issuing register requests to the channel map
`default_nettype none
module sscm_host (
   // clock
   input wire logic ref_clk,
   // register access
   output var sscm_pkg::sscm_req_s reg_req,
   input wire logic [23:0] reg_rdata,
   // device status
   input wire logic scan_active
);
   timeunit 1ns;
   timeprecision 1ps;
   initial reg_req = '0;
   // one write; map writes wait for idle first
   task automatic wr(input logic [3:0] a, input logic [23:0] d);
      int n;
      n = 0;
      // no map write while a scan is active
      while (a == 4'h5 && scan_active !== 1'b0 && n < 3000) begin
         @(posedge ref_clk);
         #2;
         n++;
      end
      wr_now(a, d);
   endtask
   // one write with no idle wait, to probe the dropped case
   task automatic wr_now(input logic [3:0] a, input logic [23:0] d);
      @(posedge ref_clk);
      #2;
      reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge ref_clk);
      #2;
      // released fields flip so stale values never look valid
      reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
   // one read; data lands at the taking edge and is sampled one cycle later
   task automatic rd(input logic [3:0] a, output logic [23:0] d);
      @(posedge ref_clk);
      #2;
      reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 24'hA5_5A5A};
      @(posedge ref_clk);
      #2;
      reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 24'h5A_A5A5};
      @(posedge ref_clk);
      #2;
      d = reg_rdata;
   endtask
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench for the scan sequencer channel map
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SWL = 2; // shortened switch step
   localparam int MXL = 1; // shortened mux step
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   sscm_pkg::sscm_req_s reg_req;
   logic [23:0] reg_rdata, rd_v;
   logic [7:0] sw_steps = 8'h00;
   logic [7:0] mux_steps = 8'h00;
   logic scan_start = 1'b0;
   logic conv_done = 1'b0;
   logic conv_start, chan_valid, rdy_n, map_err, ord_err, active;
   logic [2:0] chan_sel;
   logic [5:0] gpo;
   logic [1:0] range;
   int error_cnt = 0;
   int checks = 0;
   int rdy_cnt = 0;
   int lat;
   logic [2:0] sel_q[$];
   logic [5:0] gpo_q[$];
   // error flag cases: map value, expected {map error, order error}
   logic [23:0] mv[6] = '{24'h00_0002, 24'h00_001E, 24'h00_001C,
      24'h00_0604, 24'h00_4141, 24'h00_4161};
   logic [1:0] fv[6] = '{2'h1, 2'h1, 2'h0, 2'h0, 2'h2, 2'h0};
   // delay cases: enables, switch steps, mux steps
   logic [23:0] dv[5] = '{24'h00_0400, 24'h00_0400, 24'h00_0000,
      24'h00_0200, 24'h00_0600};
   int sv[5] = '{2, 0, 5, 0, 1};
   int xv[5] = '{0, 0, 0, 3, 2};
   always #25 ref_clk = ~ref_clk;
   // count ready pulses away from the launching edge
   always @(negedge ref_clk) if (rdy_n === 1'b0) rdy_cnt++;
   sscm_host i_host (.ref_clk(ref_clk), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .scan_active(active));
   sscm_core #(.SW_LEN(SWL), .MUX_LEN(MXL)) i_dut (.ref_clk(ref_clk),
      .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .switch_delay_steps(sw_steps), .mux_delay_steps(mux_steps),
      .scan_start(scan_start), .conv_done(conv_done),
      .conv_start(conv_start), .chan_select(chan_sel),
      .chan_select_valid(chan_valid), .gpo_drive(gpo),
      .data_ready_n(rdy_n), .fifo_clock_range(range),
      .output_mapping_error(map_err), .scan_order_error(ord_err),
      .scan_active(active));
   task automatic chk(input string nm, input logic [23:0] s, e);
      checks++;
      if (s !== e) begin
         error_cnt++;
         $display("[ERR] %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // one scan; converter answers one cycle after each start
   task automatic scan(input int nch);
      int n;
      sel_q.delete();
      gpo_q.delete();
      rdy_cnt = 0;
      @(posedge ref_clk);
      #2;
      scan_start = 1'b1;
      @(posedge ref_clk);
      #2;
      scan_start = 1'b0;
      for (int c = 0; c < nch; c++) begin
         n = 0;
         while (conv_start !== 1'b1 && n < 3000) begin
            @(posedge ref_clk);
            #2;
            n++;
         end
         if (c == 0) lat = n;
         sel_q.push_back(chan_sel);
         gpo_q.push_back(gpo);
         chk("valid", 24'(chan_valid), 24'h00_0001);
         chk("busy", 24'(active), 24'h00_0001);
         @(posedge ref_clk);
         #2;
         conv_done = 1'b1;
         @(posedge ref_clk);
         #2;
         conv_done = 1'b0;
      end
      n = 0;
      while (active !== 1'b0 && n < 3000) begin
         @(posedge ref_clk);
         #2;
         n++;
      end
      repeat (3) @(posedge ref_clk);
      #2;
   endtask
   initial begin
      #2_000_000;
      error_cnt++;
      finish_test();
   end
   initial begin
      repeat (4) @(posedge ref_clk);
      #2;
      rst_b = 1'b1;
      i_host.rd(4'h4, rd_v);
      chk("seq rst", rd_v, 24'h00_0001);
      i_host.rd(4'h5, rd_v);
      chk("map rst", rd_v, 24'h00_0000);
      for (int r = 0; r < 4; r++) begin
         i_host.wr(4'h4, 24'h00_0700 | 24'(r));
         i_host.rd(4'h4, rd_v);
         chk("seq", rd_v, 24'h00_0700 | 24'(r));
         chk("range", 24'(range), 24'(r));
      end
      i_host.wr(4'h4, 24'hFF_FFFF);
      i_host.rd(4'h4, rd_v);
      chk("seq rsvd", rd_v, 24'h00_0703);
      i_host.wr(4'h6, 24'h12_3456);
      i_host.rd(4'h6, rd_v);
      chk("unmapped", rd_v, 24'h00_0000);
      $display("test registers done");
      for (int i = 0; i < 6; i++) begin
         i_host.wr(4'h5, mv[i]);
         i_host.rd(4'h5, rd_v);
         chk("map", rd_v, mv[i]);
         chk("ord err", 24'(ord_err), 24'(fv[i][0]));
         chk("map err", 24'(map_err), 24'(fv[i][1]));
      end
      $display("test error flags done");
      // ch5 first with bump 4, ch4 off, ch3 second with bump off
      i_host.wr(4'h5, 24'h87_2DAA);
      for (int s = 0; s < 2; s++) begin
         i_host.wr(4'h4, 24'(s) << 8);
         scan(2);
         chk("lat", 24'(lat), 24'h00_0002);
         chk("ch a", 24'(sel_q[0]), 24'h00_0005);
         chk("ch b", 24'(sel_q[1]), 24'h00_0003);
         chk("bump a", 24'(gpo_q[0]), 24'h00_0010);
         chk("bump b", 24'(gpo_q[1]), 24'h00_0000);
         chk("rdy", 24'(rdy_cnt), 24'(2 - s));
         chk("gpo idle", 24'(gpo), 24'h00_0000);
      end
      $display("test scan order done");
      i_host.wr(4'h5, 24'h87_0000);
      for (int i = 0; i < 5; i++) begin
         i_host.wr(4'h4, dv[i]);
         sw_steps = 8'(sv[i]);
         mux_steps = 8'(xv[i]);
         scan(1);
         chk("delay", 24'(lat), 24'(2 + (dv[i][10] ? sv[i] * SWL : 0)
            + (dv[i][9] ? xv[i] * MXL : 0)));
      end
      $display("test delays done");
      // map write mid-scan must be dropped
      i_host.wr(4'h4, 24'h00_0400);
      sw_steps = 8'h04;
      fork
         scan(1);
         begin
            repeat (3) @(posedge ref_clk);
            i_host.wr_now(4'h5, 24'h00_0002);
         end
      join
      i_host.rd(4'h5, rd_v);
      chk("map lock", rd_v, 24'h87_0000);
      chk("lock lat", 24'(lat), 24'(2 + 4 * SWL));
      chk("lock ord", 24'(ord_err), 24'h00_0000);
      $display("test map lock done");
      // second reset in mid-run restores defaults
      @(posedge ref_clk);
      #2;
      rst_b = 1'b0;
      repeat (2) @(posedge ref_clk);
      #2;
      rst_b = 1'b1;
      i_host.rd(4'h5, rd_v);
      chk("map rst2", rd_v, 24'h00_0000);
      chk("range rst2", 24'(range), 24'h00_0001);
      $display("test reset done");
      finish_test();
   end
endmodule
`default_nettype wire
